//--- logic/bmc_buck_mode_control.v
// Mode decode, setpoint, reference slew and current-limit flagging for the
// two scaling buck units. Control bits arrive as plain ports from the I2C
// register bank; limit comparators and power state are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"

module bmc_buck_mode_control #(
	parameter integer NUM_UNITS = 2,
	parameter integer DEB_CYCLES = `BMC_DEB_NS / `BMC_CLK_NS
) (
	input  wire                               clk,
	input  wire                               resetn,
	input  wire                               clk_en,
	input  wire [`BMC_PS_W-1:0]               power_state,
	input  wire                               host_reset_out,
	input  wire [NUM_UNITS-1:0]               scaling_disable_fuse,
	input  wire [NUM_UNITS*`BMC_SP_W-1:0]     fused_setpoint,
	input  wire [NUM_UNITS-1:0]               buck_on,
	input  wire [NUM_UNITS-1:0]               standby_keep_on,
	input  wire [NUM_UNITS-1:0]               sleep_keep_on,
	input  wire [NUM_UNITS-1:0]               low_bias_request,
	input  wire [NUM_UNITS-1:0]               force_pwm,
	input  wire [NUM_UNITS-1:0]               slew_select,
	input  wire [NUM_UNITS-1:0]               setpoint_wr,
	input  wire [1:0]                         setpoint_sel,
	input  wire [`BMC_SP_W-1:0]               setpoint_wdata,
	input  wire [NUM_UNITS-1:0]               hs_limit_hit,
	input  wire [NUM_UNITS-1:0]               ls_limit_hit,
	input  wire [NUM_UNITS-1:0]               sense_clear,
	input  wire [NUM_UNITS-1:0]               status_clear,
	output reg  [NUM_UNITS*`BMC_MODE_W-1:0]   mode_out,
	output reg  [NUM_UNITS-1:0]               discharge_on,
	output reg  [NUM_UNITS-1:0]               scaling_ref_on,
	output reg  [NUM_UNITS-1:0]               fixed_ref_on,
	output reg  [NUM_UNITS-1:0]               hs_gate_block,
	output reg  [NUM_UNITS-1:0]               ls_gate_block,
	output reg  [NUM_UNITS-1:0]               hs_limit_sense,
	output reg  [NUM_UNITS-1:0]               ls_limit_sense,
	output reg  [NUM_UNITS-1:0]               hs_limit_status,
	output reg  [NUM_UNITS-1:0]               ls_limit_status,
	output reg  [NUM_UNITS*`BMC_SP_W-1:0]     run_setpoint,
	output reg  [NUM_UNITS*`BMC_SP_W-1:0]     standby_setpoint,
	output reg  [NUM_UNITS*`BMC_SP_W-1:0]     sleep_setpoint,
	output reg  [NUM_UNITS*`BMC_REF_W-1:0]    ref_level
);

	// =====================================================
	// Timing constants
	// =====================================================
	localparam integer SLEW0_CYC = `BMC_SLEW0_NS / `BMC_CLK_NS;
	localparam integer SLEW1_CYC = `BMC_SLEW1_NS / `BMC_CLK_NS;
	localparam integer DEB_W = 22;
	localparam integer SLW_W = 10;
	localparam integer DEB_LAST_I = DEB_CYCLES - 1;
	localparam integer SLEW0_LAST_I = SLEW0_CYC - 1;
	localparam integer SLEW1_LAST_I = SLEW1_CYC - 1;
	// Counter widths fit the documented counts; longer ones need wider
	localparam [DEB_W-1:0] DEB_LAST = DEB_LAST_I[DEB_W-1:0];
	localparam [SLW_W-1:0] SLEW0_LAST = SLEW0_LAST_I[SLW_W-1:0];
	localparam [SLW_W-1:0] SLEW1_LAST = SLEW1_LAST_I[SLW_W-1:0];
	localparam [1:0] SEL_RUN = 2'h0;
	localparam [1:0] SEL_STBY = 2'h1;
	localparam [1:0] SEL_SLEEP = 2'h2;

	// =====================================================
	// Functions
	// =====================================================
	// Persistence count: saturates, restarts whenever the fault drops
	function [DEB_W-1:0] deb_next;
		input [DEB_W-1:0] cnt;
		input             hit;
		begin
			if (!hit)
				deb_next = {DEB_W{1'b0}};
			else if (cnt == DEB_LAST)
				deb_next = cnt;
			else
				deb_next = cnt + 1'b1;
		end
	endfunction

	// Sticky flag: a new event beats a clear in the same cycle
	function sticky_next;
		input set;
		input flag;
		input clr;
		begin
			sticky_next = set || (flag && !clr);
		end
	endfunction

	// Code to reference in 0.1 mV units
	function [`BMC_REF_W-1:0] code_to_ref;
		input [`BMC_SP_W-1:0] code;
		input                 fixed;
		begin
			if (!fixed) begin
				code_to_ref = `BMC_REF_BASE + code * `BMC_REF_STEP;
			end else begin
				case (code)
				6'h00: code_to_ref = `BMC_FIX_0;
				6'h01: code_to_ref = `BMC_FIX_1;
				6'h02: code_to_ref = `BMC_FIX_2;
				6'h03: code_to_ref = `BMC_FIX_3;
				6'h04: code_to_ref = `BMC_FIX_4;
				6'h05: code_to_ref = `BMC_FIX_5;
				6'h06: code_to_ref = `BMC_FIX_6;
				default: code_to_ref = `BMC_FIX_HI;
				endcase
			end
		end
	endfunction

	// Mode decode from power state and per-unit bits
	function [`BMC_MODE_W-1:0] decode_mode;
		input [`BMC_PS_W-1:0] ps;
		input                 en;
		input                 stby;
		input                 slp;
		input                 lpwr;
		input                 fpwm;
		reg kept;
		begin
			kept = 1'b0;
			case (ps)
			`BMC_PS_RUN:   kept = 1'b1;
			`BMC_PS_STBY:  kept = stby;
			`BMC_PS_SLEEP: kept = slp;
			default:       kept = 1'b0;
			endcase
			if (!en || !kept)
				decode_mode = `BMC_MODE_OFF;
			else if (fpwm)
				decode_mode = `BMC_MODE_FPWM;
			else if (lpwr && ps != `BMC_PS_RUN)
				decode_mode = `BMC_MODE_LOWB;
			else
				decode_mode = `BMC_MODE_ADAPT;
		end
	endfunction

	// =====================================================
	// Input synchronisers
	// =====================================================
	// Fuse and control bits are static or same-clock, so not synced
	reg [`BMC_PS_W-1:0] ps_s1_reg;
	reg [`BMC_PS_W-1:0] ps_s2_reg;
	reg [`BMC_PS_W-1:0] ps_prev_reg;
	reg [NUM_UNITS-1:0] hs_s1_reg;
	reg [NUM_UNITS-1:0] hs_s2_reg;
	reg [NUM_UNITS-1:0] ls_s1_reg;
	reg [NUM_UNITS-1:0] ls_s2_reg;
	reg                 hr_s1_reg;
	reg                 hr_s2_reg;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ps_s1_reg   <= `BMC_PS_OFF;
			ps_s2_reg   <= `BMC_PS_OFF;
			ps_prev_reg <= `BMC_PS_OFF;
			hs_s1_reg   <= {NUM_UNITS{1'b0}};
			hs_s2_reg   <= {NUM_UNITS{1'b0}};
			ls_s1_reg   <= {NUM_UNITS{1'b0}};
			ls_s2_reg   <= {NUM_UNITS{1'b0}};
			hr_s1_reg   <= 1'b0;
			hr_s2_reg   <= 1'b0;
		end else if (clk_en) begin
			ps_s1_reg   <= power_state;
			ps_s2_reg   <= ps_s1_reg;
			ps_prev_reg <= ps_s2_reg;
			hs_s1_reg   <= hs_limit_hit;
			hs_s2_reg   <= hs_s1_reg;
			ls_s1_reg   <= ls_limit_hit;
			ls_s2_reg   <= ls_s1_reg;
			hr_s1_reg   <= host_reset_out;
			hr_s2_reg   <= hr_s1_reg;
		end
	end

	// Start-up edge: rails-off to run
	wire startup = (ps_prev_reg == `BMC_PS_OFF) &&
		(ps_s2_reg == `BMC_PS_RUN);

	// =====================================================
	// Per-unit logic
	// =====================================================
	// Limit-hit gating adds three cycles (two sync, one output register); analog path must act faster.
	genvar u;
	generate
		for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
			reg [DEB_W-1:0]      hs_cnt_reg;
			reg [DEB_W-1:0]      ls_cnt_reg;
			reg [SLW_W-1:0]      slew_cnt_reg;
			reg [`BMC_REF_W-1:0] target;
			wire                 fixed = scaling_disable_fuse[u];
			wire [`BMC_SP_W-1:0] fuse_sp =
				fused_setpoint[u*`BMC_SP_W +: `BMC_SP_W];
			wire                 wr_ok = setpoint_wr[u] && !fixed &&
				hr_s2_reg;
			wire [`BMC_REF_W-1:0] cur =
				ref_level[u*`BMC_REF_W +: `BMC_REF_W];
			wire [SLW_W-1:0]      slew_last =
				slew_select[u] ? SLEW1_LAST : SLEW0_LAST;

			always @* begin
				case (ps_s2_reg)
				`BMC_PS_STBY: target = code_to_ref(
					standby_setpoint[u*`BMC_SP_W +: `BMC_SP_W], fixed);
				`BMC_PS_SLEEP: target = code_to_ref(
					sleep_setpoint[u*`BMC_SP_W +: `BMC_SP_W], fixed);
				default: target = code_to_ref(
					run_setpoint[u*`BMC_SP_W +: `BMC_SP_W], fixed);
				endcase
			end

			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					mode_out[u*`BMC_MODE_W +: `BMC_MODE_W] <= `BMC_MODE_OFF;
					discharge_on[u]    <= 1'b1;
					scaling_ref_on[u]  <= 1'b0;
					fixed_ref_on[u]    <= 1'b0;
					hs_gate_block[u]   <= 1'b0;
					ls_gate_block[u]   <= 1'b0;
					hs_limit_sense[u]  <= 1'b0;
					ls_limit_sense[u]  <= 1'b0;
					hs_limit_status[u] <= 1'b0;
					ls_limit_status[u] <= 1'b0;
					hs_cnt_reg         <= {DEB_W{1'b0}};
					ls_cnt_reg         <= {DEB_W{1'b0}};
					slew_cnt_reg       <= {SLW_W{1'b0}};
					run_setpoint[u*`BMC_SP_W +: `BMC_SP_W]     <= `BMC_SP_RESET;
					standby_setpoint[u*`BMC_SP_W +: `BMC_SP_W] <= `BMC_SP_RESET;
					sleep_setpoint[u*`BMC_SP_W +: `BMC_SP_W]   <= `BMC_SP_RESET;
					ref_level[u*`BMC_REF_W +: `BMC_REF_W] <= `BMC_REF_BASE;
				end else if (clk_en) begin
					// =========================
					// Mode and reference path
					// =========================
					// Decoded mode registered, so applies next cycle
					mode_out[u*`BMC_MODE_W +: `BMC_MODE_W] <= decode_mode(
						ps_s2_reg, buck_on[u], standby_keep_on[u],
						sleep_keep_on[u], low_bias_request[u],
						force_pwm[u]);
					// Off always engages the output discharge resistor
					discharge_on[u] <= (decode_mode(ps_s2_reg, buck_on[u],
						standby_keep_on[u], sleep_keep_on[u],
						low_bias_request[u], force_pwm[u])
						== `BMC_MODE_OFF);
					scaling_ref_on[u] <= !fixed;
					fixed_ref_on[u]   <= fixed;
					hs_gate_block[u]  <= hs_s2_reg[u];
					ls_gate_block[u]  <= ls_s2_reg[u];

					// =========================
					// Current-limit flags
					// =========================
					// Sticky sense; a new hit beats the clear
					hs_limit_sense[u] <= sticky_next(hs_s2_reg[u],
						hs_limit_sense[u], sense_clear[u]);
					ls_limit_sense[u] <= sticky_next(ls_s2_reg[u],
						ls_limit_sense[u], sense_clear[u]);

					// Persistence counters restart when the fault drops
					hs_cnt_reg <= deb_next(hs_cnt_reg, hs_s2_reg[u]);
					ls_cnt_reg <= deb_next(ls_cnt_reg, ls_s2_reg[u]);
					hs_limit_status[u] <= sticky_next(hs_s2_reg[u] &&
						hs_cnt_reg == DEB_LAST, hs_limit_status[u],
						status_clear[u]);
					ls_limit_status[u] <= sticky_next(ls_s2_reg[u] &&
						ls_cnt_reg == DEB_LAST, ls_limit_status[u],
						status_clear[u]);

					// =========================
					// Setpoint fields
					// =========================
					// Start-up load wins over a host write
					if (startup) begin
						run_setpoint[u*`BMC_SP_W +: `BMC_SP_W]     <= fuse_sp;
						standby_setpoint[u*`BMC_SP_W +: `BMC_SP_W] <= fuse_sp;
						sleep_setpoint[u*`BMC_SP_W +: `BMC_SP_W]   <= fuse_sp;
					end else if (wr_ok) begin
						case (setpoint_sel)
						SEL_RUN: run_setpoint[u*`BMC_SP_W +: `BMC_SP_W]
							<= setpoint_wdata;
						SEL_STBY: standby_setpoint[u*`BMC_SP_W +: `BMC_SP_W]
							<= setpoint_wdata;
						SEL_SLEEP: sleep_setpoint[u*`BMC_SP_W +: `BMC_SP_W]
							<= setpoint_wdata;
						default: ;
						endcase
					end

					// =========================
					// Reference slew
					// =========================
					// Stepped slew; fixed mode jumps straight to the target
					// Last step is clamped so it lands exactly on target
					if (fixed || cur == target) begin
						ref_level[u*`BMC_REF_W +: `BMC_REF_W] <= target;
						slew_cnt_reg <= {SLW_W{1'b0}};
					end else if (slew_cnt_reg >= slew_last) begin
						slew_cnt_reg <= {SLW_W{1'b0}};
						if (cur < target)
							ref_level[u*`BMC_REF_W +: `BMC_REF_W] <=
								(target - cur < `BMC_REF_STEP) ? target :
								cur + `BMC_REF_STEP;
						else
							ref_level[u*`BMC_REF_W +: `BMC_REF_W] <=
								(cur - target < `BMC_REF_STEP) ? target :
								cur - `BMC_REF_STEP;
					end else begin
						slew_cnt_reg <= slew_cnt_reg + 1'b1;
					end
				end
			end
		end
	endgenerate

endmodule // bmc_buck_mode_control
`default_nettype wire

//--- shared/bmc_defs.vh
// Constants for the buck mode control block.
// Assumes inclusion by bare name from logic files only.
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH

// Power states
`define BMC_PS_W        2
`define BMC_PS_OFF      2'h0
`define BMC_PS_RUN      2'h1
`define BMC_PS_STBY     2'h2
`define BMC_PS_SLEEP    2'h3

// Operating mode codes (one-hot)
`define BMC_MODE_W      4
`define BMC_MODE_OFF    4'h1
`define BMC_MODE_ADAPT  4'h2
`define BMC_MODE_FPWM   4'h4
`define BMC_MODE_LOWB   4'h8

// Setpoint layout
`define BMC_SP_W        6
`define BMC_SP_RESET    6'h00
`define BMC_REF_W       16
// Reference in units of 0.1 mV
`define BMC_REF_BASE    16'h1770
`define BMC_REF_STEP    16'h007d
`define BMC_FIX_0       16'h2af8
`define BMC_FIX_1       16'h2ee0
`define BMC_FIX_2       16'h34bc
`define BMC_FIX_3       16'h3a98
`define BMC_FIX_4       16'h4650
`define BMC_FIX_5       16'h61a8
`define BMC_FIX_6       16'h7530
`define BMC_FIX_HI      16'h80e8

// Timing, clock period 4 ns
`define BMC_CLK_NS      4
`define BMC_SLEW0_NS    2000
`define BMC_SLEW1_NS    4000
`define BMC_DEB_NS      8000000

`endif

//--- sim/bmc_buck_mode_control_chk.sv
// Checker for unit 0 of the buck mode control block.
// Assumes binding to the top module; control bits change off clk edges.
`timescale 1ns/1ps
`default_nettype none
module bmc_chk #(
	parameter integer DEB_CYCLES = 20
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic [1:0]  power_state,
	input wire logic        host_reset_out,
	input wire logic [1:0]  scaling_disable_fuse,
	input wire logic [1:0]  buck_on,
	input wire logic [1:0]  standby_keep_on,
	input wire logic [1:0]  sleep_keep_on,
	input wire logic [1:0]  low_bias_request,
	input wire logic [1:0]  force_pwm,
	input wire logic [1:0]  setpoint_wr,
	input wire logic [1:0]  setpoint_sel,
	input wire logic [5:0]  setpoint_wdata,
	input wire logic [1:0]  hs_limit_hit,
	input wire logic [7:0]  mode_out,
	input wire logic [1:0]  discharge_on,
	input wire logic [1:0]  scaling_ref_on,
	input wire logic [1:0]  fixed_ref_on,
	input wire logic [1:0]  hs_gate_block,
	input wire logic [1:0]  hs_limit_sense,
	input wire logic [1:0]  hs_limit_status,
	input wire logic [11:0] run_setpoint
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire [3:0] m0 = mode_out[3:0];
	logic [31:0] hit_run_reg;
	// Raw pin run length; bounds how early status may rise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn || !hs_limit_hit[0]) hit_run_reg <= 32'h0;
		else hit_run_reg <= hit_run_reg + 32'h1;
	end
	// ====================================================
	// Assertions
	a_off_discharge: assert property (discharge_on[0] == (m0 == 4'h1))
		else $error("discharge does not follow off mode");
	a_ref_path_select: assert property (clk_en ##1 clk_en |->
		scaling_ref_on[0] != fixed_ref_on[0]
		&& fixed_ref_on[0] == scaling_disable_fuse[0])
		else $error("reference path does not follow fuse");
	a_unit_disable: assert property (!buck_on[0] && clk_en |=> m0 == 4'h1)
		else $error("unit on with enable low");
	a_run_force_pwm: assert property ((power_state == 2'h1)[*4]
		##0 (buck_on[0] && force_pwm[0]) |=> m0 == 4'h4)
		else $error("forced pwm not taken");
	a_run_no_lowbias: assert property ((power_state == 2'h1)[*4] ##0
		(buck_on[0] && low_bias_request[0] && !force_pwm[0]) |=> m0 == 4'h2)
		else $error("run with low bias request not adaptive");
	a_standby_drop: assert property ((power_state == 2'h2)[*4]
		##0 !standby_keep_on[0] |=> m0 == 4'h1)
		else $error("standby without keep-on not off");
	a_sleep_low_bias: assert property ((power_state == 2'h3)[*4] ##0
		(buck_on[0] && sleep_keep_on[0] && low_bias_request[0]
		&& !force_pwm[0]) |=> m0 == 4'h8)
		else $error("sleep low bias not entered");
	a_gate_follows: assert property (hs_limit_hit[0][*4] |=> hs_gate_block[0])
		else $error("high side not blocked");
	a_sense_prompt: assert property (hs_limit_hit[0][*3] |=> hs_limit_sense[0])
		else $error("sense flag late");
	a_status_debounce: assert property ($rose(hs_limit_status[0]) |->
		hit_run_reg >= DEB_CYCLES)
		else $error("status set before debounce");
	a_setpoint_take: assert property ((power_state == 2'h1 && host_reset_out)[*8]
		##0 (setpoint_wr[0] && setpoint_sel == 2'h0 && !scaling_disable_fuse[0])
		|=> run_setpoint[5:0] == $past(setpoint_wdata))
		else $error("run setpoint write lost");
	c_low_bias: cover property (m0 == 4'h8);
	c_status: cover property (hs_limit_status[0]);
	c_write: cover property (setpoint_wr[0] && host_reset_out);
endmodule // bmc_chk
bind bmc_buck_mode_control bmc_chk #(.DEB_CYCLES(DEB_CYCLES)) chk_u (.*);
`default_nettype wire

//--- sim/bmc_host_model.sv
// Host model: issues setpoint writes to the block for the bench.
// Assumes clk is the block clock; drives on falling edges only.
`timescale 1ns/1ps
`default_nettype none
module bmc_host_model (
	input  wire logic [1:0] scaling_disable_fuse,
	input  wire logic       clk,
	output var  logic [1:0] setpoint_wr,
	output var  logic [1:0] setpoint_sel,
	output var  logic [5:0] setpoint_wdata
);
	initial begin
		setpoint_wr = 2'h0;
		setpoint_sel = 2'h3;
		setpoint_wdata = 6'h2a;
	end
	// ====================================================
	// Write task
	task automatic write_sp(input int u, input logic [1:0] s,
			input logic [5:0] d);
		// Fixed-reference units are read-only: never written
		if (scaling_disable_fuse[u]) return;
		@(negedge clk);
		setpoint_wr[u] = 1'b1;
		setpoint_sel = s;
		setpoint_wdata = d;
		@(negedge clk);
		setpoint_wr = 2'h0;
		setpoint_sel = 2'h3;
		// Released bus shows inverse data, not a stale copy
		setpoint_wdata = ~d;
	endtask
endmodule // bmc_host_model
`default_nettype wire

//--- sim/tb_buck_mode_control.sv
// Self-checking bench for the buck mode control block.
// Assumes a short debounce count and the host model for setpoint writes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_buck_mode_control;
	logic        clk, resetn, clk_en, host_reset_out;
	logic [1:0]  power_state, scaling_disable_fuse, buck_on, standby_keep_on;
	logic [1:0]  sleep_keep_on, low_bias_request, force_pwm, slew_select;
	logic [1:0]  hs_limit_hit, ls_limit_hit, sense_clear, status_clear;
	logic [11:0] fused_setpoint;
	wire  [1:0]  setpoint_wr, setpoint_sel, discharge_on, scaling_ref_on;
	wire  [5:0]  setpoint_wdata;
	wire  [7:0]  mode_out;
	wire  [1:0]  fixed_ref_on, hs_gate_block, ls_gate_block, hs_limit_sense;
	wire  [1:0]  ls_limit_sense, hs_limit_status, ls_limit_status;
	wire  [11:0] run_setpoint, standby_setpoint, sleep_setpoint;
	wire  [31:0] ref_level;
	int          mismatches, check_count;
	bmc_buck_mode_control #(.DEB_CYCLES(20)) dut_u (.*);
	bmc_host_model host_u (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ====================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wait_ref(input logic [15:0] t, input int lo);
		int n;
		n = 0;
		while (ref_level[15:0] !== t && n < 9000) begin
			cyc(1);
			n++;
		end
		if (n >= 9000) begin
			mismatches++;
			print_verdict;
		end
		`CHK("ramp time", 1'b1, n >= lo)
	endtask
	function automatic logic [3:0] exp_mode(input logic [1:0] ps,
			input logic en, sb, sl, lp, fp);
		if (!en || (ps == 2'h2 && !sb) || (ps == 2'h3 && !sl)) return 4'h1;
		if (fp) return 4'h4;
		return (lp && ps != 2'h1) ? 4'h8 : 4'h2;
	endfunction
	// ====================================================
	// Scenarios
	task automatic t_reset;
		`CHK("mode", 8'h11, mode_out)
		`CHK("discharge", 2'h3, discharge_on)
		// Fixed unit 1 jumps to code 0 level one edge after release
		`CHK("ref", 32'h2af81770, ref_level)
		$display("test reset done");
	endtask
	task automatic t_startup;
		buck_on = 2'h3;
		power_state = 2'h1;
		cyc(8);
		`CHK("run_sp", 12'h84a, run_setpoint)
		`CHK("stby_sp", 12'h84a, standby_setpoint)
		`CHK("sleep_sp", 12'h84a, sleep_setpoint)
		`CHK("scale_ref", 2'h1, scaling_ref_on)
		`CHK("fixed_ref", 2'h2, fixed_ref_on)
		wait_ref(16'h1c52, 4500);
		`CHK("fixed_level", 16'h80e8, ref_level[31:16])
		$display("test startup done");
	endtask
	task automatic t_modes;
		logic [3:0] e;
		for (int i = 0; i < 96; i++) begin
			power_state = 2'(i / 32 + 1);
			buck_on = {2{i[4]}};
			standby_keep_on = {2{i[3]}};
			sleep_keep_on = {2{i[2]}};
			low_bias_request = {2{i[1]}};
			force_pwm = {2{i[0]}};
			e = exp_mode(power_state, i[4], i[3], i[2], i[1], i[0]);
			cyc(4);
			`CHK("mode", {e, e}, mode_out)
			`CHK("discharge", {2{e == 4'h1}}, discharge_on)
		end
		$display("test modes done");
	endtask
	task automatic t_write;
		power_state = 2'h1;
		buck_on = 2'h3;
		cyc(4);
		host_u.write_sp(0, 2'h0, 6'h10);
		`CHK("run_sp_held", 6'h0a, run_setpoint[5:0])
		host_reset_out = 1'b1;
		slew_select = 2'h1;
		cyc(4);
		host_u.write_sp(0, 2'h1, 6'h05);
		host_u.write_sp(0, 2'h2, 6'h03);
		host_u.write_sp(1, 2'h0, 6'h00);
		host_u.write_sp(0, 2'h0, 6'h10);
		`CHK("run_sp", 12'h850, run_setpoint)
		`CHK("stby_sp", 12'h845, standby_setpoint)
		`CHK("sleep_sp", 12'h843, sleep_setpoint)
		wait_ref(16'h1f40, 5500);
		$display("test write done");
	endtask
	task automatic t_limit;
		hs_limit_hit = 2'h1;
		ls_limit_hit = 2'h2;
		cyc(5);
		`CHK("sense", 4'h6, {hs_limit_sense, ls_limit_sense})
		`CHK("blocks", 4'h6, {hs_gate_block, ls_gate_block})
		`CHK("early_status", 4'h0, {hs_limit_status, ls_limit_status})
		cyc(30);
		`CHK("status", 4'h6, {hs_limit_status, ls_limit_status})
		hs_limit_hit = 2'h0;
		ls_limit_hit = 2'h0;
		cyc(5);
		`CHK("unblock", 4'h0, {hs_gate_block, ls_gate_block})
		`CHK("sticky", 4'h6, {hs_limit_sense, ls_limit_sense})
		sense_clear = 2'h3;
		status_clear = 2'h3;
		cyc(1);
		sense_clear = 2'h0;
		status_clear = 2'h0;
		cyc(1);
		`CHK("cleared", 8'h00, {hs_limit_sense, ls_limit_sense,
			hs_limit_status, ls_limit_status})
		$display("test limit done");
	endtask
	initial begin
		{resetn, host_reset_out, power_state, buck_on} = 6'h0;
		clk_en = 1'b1;
		scaling_disable_fuse = 2'h2;
		fused_setpoint = 12'h84a;
		{standby_keep_on, sleep_keep_on, low_bias_request} = 6'h0;
		{force_pwm, slew_select, hs_limit_hit, ls_limit_hit} = 8'h0;
		{sense_clear, status_clear} = 4'h0;
		cyc(8);
		resetn = 1'b1;
		cyc(1);
		t_reset;
		t_startup;
		t_modes;
		t_write;
		t_limit;
		print_verdict;
	end
endmodule // tb_buck_mode_control
`default_nettype wire
